// *** period_match_timer.v ***
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "period_match_timer_regs.vh"
// How it works
// - eight-bit up-counter, readable and writable by software at any time
// - eight-bit period register, read/write, set to all ones on reset
// - counter input is instruction clock divided by 1, 4 or 16
// - postscale ratio equals the four-bit select field value plus one
// - count up from zero; after equalling period, next increment gives zero
// - matches advance postscaler; reaching selected count sets match flag bit 1
// - control bit 2 runs the timer when set, stops it when clear
// - scaler counters clear on counter write, control write and reset
// - control register writes leave the counter value untouched
// - counter clears to zero on every reset
// - unpostscaled match pulse goes out to the serial port shift clock
// - count value and match pulse go out to the pwm unit
module period_match_timer #(
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire rst_b,
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    output wire irq,
    output wire [7:0] timerCount,
    output wire periodMatch
);

////////////////////////////////////////////////////////////////////////////

function [9:0] regIndex;
    input [ADDR_W-1:0] addr;
    begin
        regIndex = addr[11:2];
    end
endfunction

// 1x selects sixteen, so bit 1 alone decides that case
function [3:0] prescaleLimit;
    input [1:0] sel;
    begin
        if (sel[1]) begin
            prescaleLimit = `PRESC_LIM_16;
        end else if (sel[0]) begin
            prescaleLimit = `PRESC_LIM_4;
        end else begin
            prescaleLimit = `PRESC_LIM_1;
        end
    end
endfunction

localparam [1:0] TRANS_NONSEQ = 2'b10;

reg [7:0] count_q;
reg [7:0] control_q;
reg [7:0] period_q;
reg flag_q;
reg enable_q;
reg irq_q;
reg periodMatch_q;

reg wrPend_q;
reg [9:0] wrIdx_q;
reg rdPend_q;
reg [9:0] rdIdx_q;
reg hreadyout_q;
reg [31:0] hrdata_q;
reg hresp_q;
reg [31:0] rdWord;

reg [1:0] instrPhase_q;

wire busReq;
wire [2:0] unusedSize;
wire wrCount;
wire wrControl;
wire wrPeriod;
wire wrFlag;
wire wrEnable;
wire runEnable;
wire [1:0] prescaleSelect;
wire [3:0] postscaleSelect;
wire [3:0] prescLimit;
wire instrTick;
wire countTick;
wire matchNow;
wire scalerClear;
wire postWrap;
wire [7:0] wrByte;

////////////////////////////////////////////////////////////////////////////
// bus decode

assign busReq = hsel && hready && (htrans == TRANS_NONSEQ);
assign unusedSize = hsize;
assign wrByte = hwdata[7:0];

assign wrCount = wrPend_q && (wrIdx_q == `IDX_COUNT);
assign wrControl = wrPend_q && (wrIdx_q == `IDX_CONTROL);
assign wrPeriod = wrPend_q && (wrIdx_q == `IDX_PERIOD);
assign wrFlag = wrPend_q && (wrIdx_q == `IDX_FLAG);
assign wrEnable = wrPend_q && (wrIdx_q == `IDX_ENABLE);

// writes take no wait; reads take one so that they see a preceding write
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wrPend_q <= 1'b0;
        wrIdx_q <= 10'h000;
    end else begin
        wrPend_q <= busReq && hwrite;
        if (busReq) begin
            wrIdx_q <= regIndex(haddr);
        end
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rdPend_q <= 1'b0;
        rdIdx_q <= 10'h000;
        hreadyout_q <= 1'b1;
    end else begin
        if (busReq) begin
            rdIdx_q <= regIndex(haddr);
        end
        if (busReq && !hwrite) begin
            rdPend_q <= 1'b1;
            hreadyout_q <= 1'b0;
        end else begin
            rdPend_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end
    end
end

always @* begin
    rdWord = 32'h0000_0000;
    case (rdIdx_q)
        `IDX_COUNT: rdWord = {24'h00_0000, count_q};
        `IDX_CONTROL: rdWord = {24'h00_0000, control_q};
        `IDX_PERIOD: rdWord = {24'h00_0000, period_q};
        `IDX_FLAG: rdWord = {30'h0000_0000, flag_q, 1'b0};
        `IDX_ENABLE: rdWord = {30'h0000_0000, enable_q, 1'b0};
        default: rdWord = 32'h0000_0000;
    endcase
end

// read data holds until the next read
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        hrdata_q <= 32'h0000_0000;
    end else if (rdPend_q) begin
        hrdata_q <= rdWord;
    end
end

////////////////////////////////////////////////////////////////////////////
// control fields

assign runEnable = control_q[`CTL_RUN_BIT];
assign prescaleSelect = control_q[`CTL_PRESC_MSB:`CTL_PRESC_LSB];
assign postscaleSelect = control_q[`CTL_POST_MSB:`CTL_POST_LSB];

// bit 7 unimplemented, reads zero
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        control_q <= `RST_CONTROL;
    end else if (wrControl) begin
        control_q <= wrByte & `CTL_MASK;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        period_q <= `RST_PERIOD;
    end else if (wrPeriod) begin
        period_q <= wrByte;
    end
end

////////////////////////////////////////////////////////////////////////////
// instruction clock and prescaler

// free-running phase; not cleared by writes, so a tick may come early
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        instrPhase_q <= 2'b00;
    end else begin
        instrPhase_q <= instrPhase_q + 2'b01;
    end
end

assign instrTick = (instrPhase_q == `INSTR_LAST);

assign prescLimit = prescaleLimit(prescaleSelect);

assign scalerClear = wrCount || wrControl;

scaler_counter #(
    .W(4)
) prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .clear(scalerClear),
    .inc(instrTick && runEnable),
    .limit(prescLimit),
    .wrap(countTick)
);

////////////////////////////////////////////////////////////////////////////
// counter and period match

assign matchNow = countTick && (count_q == period_q);

// software write beats a simultaneous increment
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        count_q <= `RST_COUNT;
    end else if (wrCount) begin
        count_q <= wrByte;
    end else if (matchNow) begin
        count_q <= 8'h00;
    end else if (countTick) begin
        count_q <= count_q + 8'h01;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        periodMatch_q <= 1'b0;
    end else begin
        periodMatch_q <= matchNow;
    end
end

scaler_counter #(
    .W(4)
) postscaler (
    .clk(clk),
    .rst_b(rst_b),
    .clear(scalerClear),
    .inc(matchNow),
    .limit(postscaleSelect),
    .wrap(postWrap)
);

////////////////////////////////////////////////////////////////////////////
// interrupt

// a new match wins over a clear in the same cycle
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        flag_q <= `RST_FLAG;
    end else if (postWrap) begin
        flag_q <= 1'b1;
    end else if (wrFlag && hwdata[`FLAG_MATCH_BIT]) begin
        flag_q <= 1'b0;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        enable_q <= `RST_ENABLE;
    end else if (wrEnable) begin
        enable_q <= hwdata[`FLAG_MATCH_BIT];
    end
end

// one cycle behind the flag, to keep the output on a flop
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        irq_q <= 1'b0;
    end else begin
        irq_q <= flag_q && enable_q;
    end
end

// only OKAY is ever answered; kept on a flop like every other output
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        hresp_q <= 1'b0;
    end else begin
        hresp_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs

assign hreadyout = hreadyout_q;
assign hrdata = hrdata_q;
assign hresp = hresp_q;
assign irq = irq_q;
assign timerCount = count_q;
assign periodMatch = periodMatch_q;

endmodule

// *** period_match_timer_regs.vh ***
`ifndef PERIOD_MATCH_TIMER_REGS_VH
`define PERIOD_MATCH_TIMER_REGS_VH

// register indices; byte address is index times four
`define IDX_FLAG 10'h00c
`define IDX_COUNT 10'h011
`define IDX_CONTROL 10'h012
`define IDX_ENABLE 10'h08c
`define IDX_PERIOD 10'h092

// timer_control fields
`define CTL_PRESC_LSB 0
`define CTL_PRESC_MSB 1
`define CTL_RUN_BIT 2
`define CTL_POST_LSB 3
`define CTL_POST_MSB 6
`define CTL_MASK 8'h7f

// flag and enable register field
`define FLAG_MATCH_BIT 1

// reset values
`define RST_COUNT 8'h00
`define RST_CONTROL 8'h00
`define RST_PERIOD 8'hff
`define RST_FLAG 1'b0
`define RST_ENABLE 1'b0

// prescale limits (ratio minus one)
`define PRESC_LIM_1 4'h0
`define PRESC_LIM_4 4'h3
`define PRESC_LIM_16 4'hf

// instruction clock is the core clock divided by four
`define INSTR_LAST 2'h3

`endif

// *** scaler_counter.v ***
`timescale 1ns/1ps
module scaler_counter #(
    parameter W = 4
) (
    input wire clk,
    input wire rst_b,
    input wire clear,
    input wire inc,
    input wire [W-1:0] limit,
    output wire wrap
);

reg [W-1:0] cnt_q;
reg [W-1:0] cnt_d;

// wraps on the event that arrives while the count is already at the limit
assign wrap = inc && !clear && (cnt_q == limit);

always @* begin
    cnt_d = cnt_q;
    if (clear) begin
        cnt_d = {W{1'b0}};
    end else if (wrap) begin
        cnt_d = {W{1'b0}};
    end else if (inc) begin
        cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cnt_q <= {W{1'b0}};
    end else begin
        cnt_q <= cnt_d;
    end
end

endmodule

// *** period_match_timer_monitor.sv ***
`timescale 1ns/1ps
module period_match_timer_monitor (
    input wire clk,
    input wire rst_b,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire irq,
    input wire [7:0] timerCount,
    input wire periodMatch
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic wrPh_q;
    // write data phase: only cause of a count change besides the timer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            wrPh_q <= 1'b0;
        else
            wrPh_q <= hsel && hready && htrans == 2'b10 && hwrite;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence rdReq;
        hsel && hready && htrans == 2'b10 && !hwrite;
    endsequence
    sequence tick;
        $changed(timerCount) && !$past(wrPh_q);
    endsequence
    AST_STEP:
        assert property (tick |-> timerCount == $past(timerCount) + 8'h01
            || timerCount == 8'h00) else $error("count jumped");
    AST_SPACE:
        assert property (tick |=> ($stable(timerCount) || $past(wrPh_q))[*3])
            else $error("count ticks too fast");
    AST_WRAP:
        assert property (periodMatch && !$past(wrPh_q) |-> timerCount == 8'h00)
            else $error("match without wrap");
    AST_PULSE:
        assert property (periodMatch |=> !periodMatch)
            else $error("match pulse too long");
    AST_STICKY:
        assert property (irq && !wrPh_q && !$past(wrPh_q) |=> irq)
            else $error("irq dropped without write");
    AST_READ:
        assert property (rdReq |=> !hreadyout ##1 hreadyout)
            else $error("read wait state wrong");
    AST_WRITE:
        assert property (wrPh_q |-> hreadyout) else $error("write stalled");
    AST_HIBITS:
        assert property (hrdata[31:8] == 24'h00_0000)
            else $error("upper read bits set");
endmodule
bind period_match_timer period_match_timer_monitor mon (.clk, .rst_b, .hsel,
    .htrans, .hwrite, .hready, .hreadyout, .hrdata, .irq, .timerCount,
    .periodMatch);

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "period_match_timer_regs.vh"
module tb_top;
    logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, rd;
    logic [7:0] c;
    wire hreadyout, hresp, irq, periodMatch;
    wire [31:0] hrdata;
    wire [7:0] timerCount;
    int miscompares = 0, checksDone = 0, i, k, p, per, post, cyc, t0;
    logic [9:0] idxs [6] = '{`IDX_COUNT, `IDX_CONTROL, `IDX_PERIOD,
        `IDX_FLAG, `IDX_ENABLE, 10'h3ff};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    // single slave, so its ready is the bus ready
    period_match_timer uut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hready(hreadyout), .hwdata, .hreadyout, .hrdata,
        .hresp, .irq, .timerCount, .periodMatch);
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task wrapUp;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, exp);
        checksDone++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask
    task rdy(inout int n);
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            wrapUp;
        end
    endtask
    // hsel stays up, so back-to-back calls never drive it twice per step
    task xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {idx, 2'b00};
        rdy(n);
        htrans <= 2'b00;
        hwdata <= wd;
        rdy(n);
        rd = hrdata;
    endtask
    function int presc(int q);
        return q == 0 ? 1 : q == 1 ? 4 : 16;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1f46));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 6; i++) begin
            xfer(0, idxs[i], 0);
            chk("reset value", rd, rv[i]);
        end
        chk("hresp", hresp, 0);
        c = $urandom;
        xfer(1, `IDX_PERIOD, c);
        xfer(0, `IDX_PERIOD, 0);
        chk("period", rd, c);
        xfer(1, `IDX_COUNT, c);
        p = $urandom & 32'h0000_007b;
        xfer(1, `IDX_CONTROL, p | 32'h0000_0080);
        xfer(0, `IDX_CONTROL, 0);
        chk("control", rd, p);
        xfer(0, `IDX_COUNT, 0);
        chk("count kept", rd, c);
        chk("count pin", timerCount, c);
        xfer(1, `IDX_ENABLE, 32'h0000_0002);
        for (i = 0; i < 6; i++) begin
            p = i % 4;
            post = (i < 2) ? 15 * i : $urandom % 16;
            per = $urandom % 4;
            // stop first so no flag lands while setting up
            xfer(1, `IDX_CONTROL, 0);
            xfer(1, `IDX_FLAG, 32'h0000_0002);
            xfer(1, `IDX_PERIOD, per);
            xfer(1, `IDX_COUNT, 0);
            xfer(1, `IDX_CONTROL, post * 8 + 4 + p);
            k = 0;
            for (cyc = 0; cyc < 9000 && irq !== 1'b1; cyc++) begin
                @(posedge clk);
                if (periodMatch === 1'b1) begin
                    k++;
                    if (k == 2)
                        chk("spacing", cyc - t0, 4 * presc(p) * (per + 1));
                    t0 = cyc;
                end
            end
            if (cyc >= 9000) begin
                miscompares++;
                wrapUp;
            end
            chk("matches per flag", k, post + 1);
        end
        xfer(1, `IDX_CONTROL, 0);
        xfer(0, `IDX_FLAG, 0);
        chk("flag sticky", rd, 32'h0000_0002);
        xfer(1, `IDX_ENABLE, 0);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 0);
        xfer(1, `IDX_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk("irq unmasked", irq, 1);
        xfer(1, `IDX_FLAG, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 0);
        xfer(1, `IDX_PERIOD, 32'h0000_00ff);
        xfer(1, `IDX_CONTROL, 32'h0000_0004);
        repeat (40) @(posedge clk);
        chk("count ran", timerCount == 8'h00, 0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("count pin reset", timerCount, 0);
        xfer(0, `IDX_COUNT, 0);
        chk("count after reset", rd, 0);
        xfer(0, `IDX_PERIOD, 0);
        chk("period after reset", rd, 32'h0000_00ff);
        wrapUp;
    end
endmodule
